/* logic/tcrm_transceiver_regs.sv */
// Purpose: Serial control slave and register bank of an optical transceiver.
// Assumes: Frame opens with a high start bit on the idle-low write line, then MSB first.
// Notes: Link logic runs on the controller's serial clock; settings cross to core_clk.
// What this block does
// RULE_01: Power register resets to all implemented ones.
// RULE_02: Power code: zeros minimum, ones maximum.
// RULE_03: Index 3 primary sensitivity, reset 0111...
// RULE_04: Index 4 alternate sensitivity, same reset.
// RULE_05: Sensitivity zeros highest, ones lowest.
// RULE_06: Main indexes 5 to 11 have no function.
// RULE_07: Extended group uses separate eight-bit index.
// RULE_08: Extended registers 0 and 1 always present.
// RULE_09: Extended 0 returns maker code.
// RULE_10: Extended 1: type, main-read, extended-read bits.
// RULE_11: Extended 4 low field: recovery time code.
// RULE_12: Extended 4 high field: stabilization time code.
// RULE_13: Extended 5 low field: extra start flags.
// RULE_14: Extended 5 high field: maximum control clock.
// RULE_15: Capability bit one means supported.
// RULE_16: Extended 6 flags feature capabilities.
// RULE_17: Extended 7 and 8 flag supported modes.
// RULE_18: Extended 9 flags baseband speed classes.
// RULE_19: Extended 10 to 14 flag sub-carrier frequencies.
// RULE_20: Extended 15-239 reserved, 240-255 vendor.
// RULE_21: Fully static, resumes at paused bit.
// RULE_22: No timeout anywhere in serial logic.
// RULE_23: Direction bit one write, zero read.
// RULE_24: Implemented bits high, unused low bits zero.
// RULE_25: Main index 1111 escapes to extended index.
// RULE_26: Follow every transaction, even unimplemented ones.
// RULE_27: Writes to read-only or reserved change nothing.
// RULE_28: Reserved capability bits read zero.
`timescale 1ns/1ps
`default_nettype none
module tcrm_transceiver_regs
    import tcrm_pkg::*;
#(
    parameter logic [2:0] DEV_ADDR = 3'h0,
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [5:0] PART_TYPE = 6'h15, // Arbitrary value
    parameter logic [7:0] PWR_MASK = 8'hFF,
    parameter logic [7:0] SENS_MASK = 8'hFF,
    parameter logic [2:0] RECOV_CODE = RECOV_0P01MS,
    parameter logic [2:0] STAB_CODE = STAB_0P5MS,
    parameter logic [2:0] FLAGS_CODE = FLAGS_0,
    parameter logic [2:0] SPEED_CODE = SPEED_4M,
    parameter logic [7:0] FEATURES = 8'h0E,
    parameter logic [7:0] MODES_PRI = 8'h01,
    parameter logic [7:0] MODES_SEC = 8'h00,
    parameter logic [7:0] SUBC_BB = 8'h00,
    parameter logic [7:0] SUBC_30 = 8'h00,
    parameter logic [7:0] SUBC_36 = 8'h00,
    parameter logic [7:0] SUBC_44 = 8'h00,
    parameter logic [7:0] SUBC_52 = 8'h00,
    parameter logic [7:0] SUBC_HI = 8'h00
)
(
    input wire logic core_clk, // Core clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic sclk, // Serial control clock from controller
    input wire logic swdat, // Serial write data, sampled on sclk rise
    output logic srdatOut, // Serial read data
    output logic srdatOe, // Read data drive enable
    output logic [7:0] txPowerLevel, // Transmit power code
    output logic [7:0] priSensitivity, // Primary sensitivity code
    output logic [7:0] altSensitivity, // Alternate sensitivity code
    output logic [7:0] activeSensitivity, // Sensitivity now in use
    output logic altSensSelected // Alternate sensitivity in use
);
    // Main and extended read support are both partial, so both read-support flags stay clear
    localparam logic MAIN_RD_ALL = 1'h0;
    localparam logic EXT_RD_ALL = 1'h0;
    localparam logic [7:0] PWR_RST = PWR_RST_ALL & PWR_MASK;
    localparam logic [7:0] SENS_RST = SENS_RST_ALL & SENS_MASK;

    logic coreRst1, coreRstn;
    logic linkRst1, linkRstn;
    tcrm_link_s lkQ, lkN;
    tcrm_core_s crQ, crN;
    logic [7:0] byteIn, rdIdx, rdData;
    logic [2:0] rdAddr;
    logic rdExt, rdHit, rdStart;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            coreRst1 <= 1'h0;
            coreRstn <= 1'h0;
        end
        else
        begin
            coreRst1 <= 1'h1;
            coreRstn <= coreRst1;
        end
    end

    // Release needs two sclk edges; sclk may stand still until the next frame
    always_ff @(posedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            linkRst1 <= 1'h0;
            linkRstn <= 1'h0;
        end
        else
        begin
            linkRst1 <= 1'h1;
            linkRstn <= linkRst1;
        end
    end

    function automatic logic addrHit(input logic [2:0] a, input logic isWrite);
        // Broadcast reaches writes and special commands only
        addrHit = (a == DEV_ADDR) || (isWrite && a == ADDR_BCAST);
    endfunction

    function automatic logic [8:0] readReg(input logic isExt, input logic [7:0] idx,
                                           input logic [7:0] pwr, input logic [7:0] pri,
                                           input logic [7:0] alt);
        readReg = 9'h000;
        if (!isExt)
        begin
            if (idx[3:0] == IDX_TX_POWER)
                readReg = {1'h1, pwr};
            else if (idx[3:0] == IDX_PRI_SENS)
                readReg = {1'h1, pri};
            else if (idx[3:0] == IDX_ALT_SENS)
                readReg = {1'h1, alt};
        end
        else if (idx == EXT_MAKER_ID)
            readReg = {1'h1, MAKER_ID}; // RULE_08 RULE_09
        else if (idx == EXT_PART_ID)
            readReg = {1'h1, EXT_RD_ALL, MAIN_RD_ALL, PART_TYPE}; // RULE_08 RULE_10
        else if (idx == EXT_TIMING)
            readReg = {1'h1, {1'h0, STAB_CODE, 1'h0, RECOV_CODE} & TIM_VALID}; // RULE_11 RULE_12
        else if (idx == EXT_PREAMBLE)
            readReg = {1'h1, {1'h0, SPEED_CODE, 1'h0, FLAGS_CODE} & PRE_VALID}; // RULE_13 RULE_14
        else if (idx == EXT_FEATURES)
            readReg = {1'h1, FEATURES}; // RULE_15 RULE_16
        else if (idx == EXT_MODES_PRI)
            readReg = {1'h1, MODES_PRI}; // RULE_17
        else if (idx == EXT_MODES_SEC)
            readReg = {1'h1, MODES_SEC & MODES_SEC_VALID}; // RULE_17 RULE_28
        else if (idx == EXT_SUBC_BB)
            readReg = {1'h1, SUBC_BB & SUBC_BB_VALID}; // RULE_18 RULE_28
        else if (idx == EXT_SUBC_30)
            readReg = {1'h1, SUBC_30 & SUBC_30_VALID}; // RULE_19 RULE_28
        else if (idx == EXT_SUBC_36)
            readReg = {1'h1, SUBC_36}; // RULE_19
        else if (idx == EXT_SUBC_44)
            readReg = {1'h1, SUBC_44}; // RULE_19
        else if (idx == EXT_SUBC_52)
            readReg = {1'h1, SUBC_52 & SUBC_52_VALID}; // RULE_19 RULE_28
        else if (idx == EXT_SUBC_HI)
            readReg = {1'h1, SUBC_HI & SUBC_HI_VALID}; // RULE_19 RULE_28
        // Reserved and vendor indexes stay silent: no drive on the read line
    endfunction

    // Read source chosen once for both the main and the extended entry point
    always_comb
    begin
        byteIn = {lkQ.shift[6:0], swdat};
        rdExt = (lkQ.state == LK_EXT);
        rdIdx = rdExt ? byteIn : {4'h0, byteIn[4:1]};
        rdAddr = rdExt ? lkQ.addr : byteIn[7:5];
        {rdHit, rdData} = readReg(rdExt, rdIdx, lkQ.txPower, lkQ.priSens, lkQ.altSens);
        rdStart = (lkQ.cnt == BIT_LAST) &&
                  ((lkQ.state == LK_EXT && lkQ.dir != DIR_WRITE) ||
                   (lkQ.state == LK_CMD && byteIn[0] != DIR_WRITE &&
                    byteIn[4:1] < IDX_VENDOR));
    end

    // Purely edge-driven on sclk: no counters of time, so a stopped clock just pauses
    always_comb
    begin
        lkN = lkQ; // RULE_21 RULE_22
        case (lkQ.state)
            LK_IDLE:
            begin
                lkN.rdOe = 1'h0;
                lkN.cnt = 3'h0;
                if (swdat)
                    lkN.state = LK_CMD;
            end
            LK_CMD, LK_EXT, LK_DATA:
            begin
                lkN.shift = byteIn;
                lkN.cnt = lkQ.cnt + 3'h1;
                if (lkQ.cnt == BIT_LAST && lkQ.state == LK_CMD)
                begin
                    lkN.addr = byteIn[7:5];
                    lkN.main_register_index = byteIn[4:1];
                    lkN.dir = byteIn[0];
                    lkN.ext = 1'h0;
                    if (byteIn[4:1] == IDX_ESCAPE)
                        lkN.state = LK_EXT; // RULE_07 RULE_25
                    else if (byteIn[4:1] >= IDX_VENDOR)
                    begin
                        lkN.state = LK_IDLE;
                        if (byteIn[0] == DIR_WRITE && addrHit(byteIn[7:5], 1'h1))
                        begin
                            if (byteIn[4:1] == IDX_RESET)
                            begin
                                lkN.txPower = PWR_RST; // RULE_01
                                lkN.priSens = SENS_RST; // RULE_03
                                lkN.altSens = SENS_RST; // RULE_04
                                lkN.altSel = 1'h0;
                                lkN.updTgl = ~lkQ.updTgl;
                            end
                            else if (byteIn[4:1] == IDX_AGC)
                            begin
                                lkN.altSel = 1'h0;
                                lkN.updTgl = ~lkQ.updTgl;
                            end
                        end
                    end
                    else if (byteIn[0] == DIR_WRITE)
                        lkN.state = LK_DATA; // RULE_23
                end
                else if (lkQ.cnt == BIT_LAST && lkQ.state == LK_EXT)
                begin
                    lkN.ext = 1'h1;
                    lkN.extIdx = byteIn;
                    if (lkQ.dir == DIR_WRITE)
                        lkN.state = LK_DATA; // RULE_23
                end
                else if (lkQ.cnt == BIT_LAST)
                begin
                    lkN.state = LK_IDLE; // RULE_26
                    // Extended and reserved writes are tracked but discarded
                    if (!lkQ.ext && addrHit(lkQ.addr, 1'h1))
                    begin
                        if (lkQ.main_register_index == IDX_TX_POWER)
                        begin
                            lkN.txPower = byteIn & PWR_MASK; // RULE_02 RULE_24
                            lkN.updTgl = ~lkQ.updTgl;
                        end
                        else if (lkQ.main_register_index == IDX_PRI_SENS)
                        begin
                            lkN.priSens = byteIn & SENS_MASK; // RULE_03 RULE_05 RULE_24
                            lkN.altSel = 1'h0;
                            lkN.updTgl = ~lkQ.updTgl;
                        end
                        else if (lkQ.main_register_index == IDX_ALT_SENS)
                        begin
                            lkN.altSens = byteIn & SENS_MASK; // RULE_04 RULE_05 RULE_24
                            lkN.altSel = 1'h1;
                            lkN.updTgl = ~lkQ.updTgl;
                        end
                    end
                end
                if (rdStart)
                begin
                    // Broadcast reads are followed but never answered
                    lkN.state = LK_RESP; // RULE_26
                    lkN.rdOe = rdHit && addrHit(rdAddr, 1'h0); // RULE_20 RULE_06
                    lkN.rdOut = rdData[7];
                    lkN.shift = {rdData[6:0], 1'h0};
                end
            end
            LK_RESP:
            begin
                if (lkQ.cnt == BIT_LAST)
                begin
                    lkN.rdOe = 1'h0;
                    lkN.rdOut = 1'h0;
                    lkN.state = LK_IDLE;
                end
                else
                begin
                    lkN.rdOut = lkQ.shift[7];
                    lkN.shift = {lkQ.shift[6:0], 1'h0};
                    lkN.cnt = lkQ.cnt + 3'h1;
                end
            end
            default:
                lkN.state = LK_IDLE;
        endcase
    end

    always_ff @(posedge sclk or negedge linkRstn)
    begin
        if (!linkRstn)
        begin
            lkQ <= '{state: LK_IDLE, cnt: 3'h0, shift: 8'h00, addr: 3'h0, main_register_index: 4'h0,
                     dir: 1'h0, ext: 1'h0, extIdx: 8'h00, txPower: PWR_RST,
                     priSens: SENS_RST, altSens: SENS_RST, altSel: 1'h0,
                     updTgl: 1'h0, rdOut: 1'h0, rdOe: 1'h0}; // RULE_01 RULE_03 RULE_04
        end
        else
            lkQ <= lkN;
    end

    // Words are stable long after the toggle moves: next update is a frame away
    always_comb
    begin
        crN = crQ;
        crN.tglSync1 = lkQ.updTgl;
        crN.tglSync2 = crQ.tglSync1;
        crN.tglSeen = crQ.tglSync2;
        if (crQ.tglSync2 != crQ.tglSeen)
        begin
            crN.txPower = lkQ.txPower;
            crN.priSens = lkQ.priSens;
            crN.altSens = lkQ.altSens;
            crN.altSel = lkQ.altSel;
            crN.actSens = lkQ.altSel ? lkQ.altSens : lkQ.priSens;
        end
    end

    always_ff @(posedge core_clk or negedge coreRstn)
    begin
        if (!coreRstn)
        begin
            crQ <= '{tglSync1: 1'h0, tglSync2: 1'h0, tglSeen: 1'h0, txPower: PWR_RST,
                     priSens: SENS_RST, altSens: SENS_RST, actSens: SENS_RST,
                     altSel: 1'h0};
        end
        else
            crQ <= crN;
    end

    assign srdatOut = lkQ.rdOut;
    assign srdatOe = lkQ.rdOe;
    assign txPowerLevel = crQ.txPower;
    assign priSensitivity = crQ.priSens;
    assign altSensitivity = crQ.altSens;
    assign activeSensitivity = crQ.actSens;
    assign altSensSelected = crQ.altSel;

    logic dataDone;
    assign dataDone = (lkQ.state == LK_DATA) && (lkQ.cnt == BIT_LAST);

    AST_PWR_RESET: assert property (@(posedge sclk) // RULE_01
        $rose(linkRstn) |-> lkQ.txPower == PWR_RST)
        else $error("power not at reset level");
    AST_SENS_RESET: assert property (@(posedge sclk) // RULE_03
        $rose(linkRstn) |-> lkQ.priSens == SENS_RST && lkQ.altSens == SENS_RST)
        else $error("sensitivity not at reset level");
    AST_LOW_BITS: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_24
        (lkQ.txPower & ~PWR_MASK) == 8'h00 && (lkQ.priSens & ~SENS_MASK) == 8'h00)
        else $error("unimplemented bit set");
    AST_RESP_LEN: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_26
        $rose(lkQ.rdOe) |-> lkQ.rdOe [*8] ##1 !lkQ.rdOe)
        else $error("response not eight bits");
    AST_NO_BCAST_READ: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_26
        (lkQ.state == LK_RESP && lkQ.addr == ADDR_BCAST) |-> !lkQ.rdOe)
        else $error("answered broadcast read");
    AST_PRI_SELECT: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_03
        (dataDone && !lkQ.ext && lkQ.main_register_index == IDX_PRI_SENS && addrHit(lkQ.addr, 1'h1))
        |=> !lkQ.altSel && lkQ.priSens == ($past(byteIn) & SENS_MASK))
        else $error("primary write not taken");
    AST_ALT_SELECT: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_04
        (dataDone && !lkQ.ext && lkQ.main_register_index == IDX_ALT_SENS && addrHit(lkQ.addr, 1'h1))
        |=> lkQ.altSel)
        else $error("alternate write not selected");
    AST_RO_WRITE: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_27
        (dataDone && lkQ.ext) |=> $stable(lkQ.txPower) && $stable(lkQ.priSens) &&
        $stable(lkQ.altSens) && $stable(lkQ.altSel) && lkQ.state == LK_IDLE)
        else $error("extended write changed state");
    AST_ESCAPE: assert property (@(posedge sclk) disable iff (!linkRstn) // RULE_25
        (lkQ.state == LK_CMD && lkQ.cnt == BIT_LAST && byteIn[4:1] == IDX_ESCAPE)
        |=> lkQ.state == LK_EXT ##8 lkQ.extIdx == $past(byteIn))
        else $error("escape not followed by index");
    AST_CROSS: assert property (@(posedge core_clk) disable iff (!coreRstn)
        $changed(crQ.tglSync2) |=> crQ.txPower == lkQ.txPower)
        else $error("core copy not updated");

    CVR_WRITE_MAIN: cover property (@(posedge sclk) disable iff (!linkRstn)
        dataDone && !lkQ.ext && lkQ.main_register_index == IDX_TX_POWER);
    CVR_READ_EXT: cover property (@(posedge sclk) disable iff (!linkRstn)
        $rose(lkQ.rdOe) && lkQ.ext);
    CVR_SPECIAL_RESET: cover property (@(posedge sclk) disable iff (!linkRstn)
        lkQ.state == LK_CMD && lkQ.cnt == BIT_LAST && byteIn[4:0] == {IDX_RESET, DIR_WRITE});
    CVR_SILENT_READ: cover property (@(posedge sclk) disable iff (!linkRstn)
        lkQ.state == LK_RESP && !lkQ.rdOe);
endmodule
`default_nettype wire

/* logic/tcrm_pkg.sv */
// Purpose: Shared constants and types for the transceiver control register map.
// Assumes: Link words are eight bits, sent most significant bit first.
// Notes: Capability codes are given as field encodings and combined in the top module.
package tcrm_pkg;
    // Command byte fields and special values
    localparam logic [2:0] ADDR_BCAST = 3'h7;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int CMD_ADDR_LSB = 5;
    localparam int CMD_MAIN_REGISTER_INDEX_LSB = 1;
    // Main index space
    localparam logic [3:0] IDX_TX_POWER = 4'h2;
    localparam logic [3:0] IDX_PRI_SENS = 4'h3;
    localparam logic [3:0] IDX_ALT_SENS = 4'h4;
    localparam logic [3:0] IDX_RSV_FIRST = 4'h5;
    localparam logic [3:0] IDX_RSV_LAST = 4'hB;
    localparam logic [3:0] IDX_VENDOR = 4'hC;
    localparam logic [3:0] IDX_RESET = 4'hD;
    localparam logic [3:0] IDX_AGC = 4'hE;
    localparam logic [3:0] IDX_ESCAPE = 4'hF;
    // Extended index space
    localparam logic [7:0] EXT_MAKER_ID = 8'h00;
    localparam logic [7:0] EXT_PART_ID = 8'h01;
    localparam logic [7:0] EXT_TIMING = 8'h04;
    localparam logic [7:0] EXT_PREAMBLE = 8'h05;
    localparam logic [7:0] EXT_FEATURES = 8'h06;
    localparam logic [7:0] EXT_MODES_PRI = 8'h07;
    localparam logic [7:0] EXT_MODES_SEC = 8'h08;
    localparam logic [7:0] EXT_SUBC_BB = 8'h09;
    localparam logic [7:0] EXT_SUBC_30 = 8'h0A;
    localparam logic [7:0] EXT_SUBC_36 = 8'h0B;
    localparam logic [7:0] EXT_SUBC_44 = 8'h0C;
    localparam logic [7:0] EXT_SUBC_52 = 8'h0D;
    localparam logic [7:0] EXT_SUBC_HI = 8'h0E;
    localparam logic [7:0] EXT_RSV_FIRST = 8'h0F;
    localparam logic [7:0] EXT_RSV_LAST = 8'hEF;
    localparam logic [7:0] EXT_VENDOR_FIRST = 8'hF0;
    // Reset values before masking with the implemented bits
    localparam logic [7:0] PWR_RST_ALL = 8'hFF;
    localparam logic [7:0] SENS_RST_ALL = 8'h7F;
    // Defined bits of partly reserved capability registers
    localparam logic [7:0] TIM_VALID = 8'h77;
    localparam logic [7:0] PRE_VALID = 8'h77;
    localparam logic [7:0] MODES_SEC_VALID = 8'h01;
    localparam logic [7:0] SUBC_BB_VALID = 8'h0E;
    localparam logic [7:0] SUBC_30_VALID = 8'hFC;
    localparam logic [7:0] SUBC_52_VALID = 8'h3F;
    localparam logic [7:0] SUBC_HI_VALID = 8'h07;
    // Recovery time after transmit
    localparam logic [2:0] RECOV_0MS = 3'h0;
    localparam logic [2:0] RECOV_0P01MS = 3'h1;
    localparam logic [2:0] RECOV_0P05MS = 3'h2;
    localparam logic [2:0] RECOV_0P1MS = 3'h3;
    localparam logic [2:0] RECOV_0P5MS = 3'h4;
    localparam logic [2:0] RECOV_1MS = 3'h5;
    localparam logic [2:0] RECOV_5MS = 3'h6;
    localparam logic [2:0] RECOV_10MS = 3'h7;
    // Power-on stabilization time; 00x and 111 are not valid
    localparam logic [2:0] STAB_0P5MS = 3'h2;
    localparam logic [2:0] STAB_1MS = 3'h3;
    localparam logic [2:0] STAB_5MS = 3'h4;
    localparam logic [2:0] STAB_10MS = 3'h5;
    localparam logic [2:0] STAB_50MS = 3'h6;
    // Extra start flags: 0,1,2,3,5,12,24,48
    localparam logic [2:0] FLAGS_0 = 3'h0;
    localparam logic [2:0] FLAGS_5 = 3'h4;
    localparam logic [2:0] FLAGS_12 = 3'h5;
    localparam logic [2:0] FLAGS_48 = 3'h7;
    // Maximum control clock; 1xx not valid
    localparam logic [2:0] SPEED_100K = 3'h0;
    localparam logic [2:0] SPEED_500K = 3'h1;
    localparam logic [2:0] SPEED_1M = 3'h2;
    localparam logic [2:0] SPEED_4M = 3'h3;

    typedef enum logic [2:0] {LK_IDLE, LK_CMD, LK_EXT, LK_DATA, LK_RESP} tcrm_link_e;

    typedef struct packed {
        tcrm_link_e state;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [2:0] addr;
        logic [3:0] main_register_index;
        logic dir;
        logic ext;
        logic [7:0] extIdx;
        logic [7:0] txPower;
        logic [7:0] priSens;
        logic [7:0] altSens;
        logic altSel;
        logic updTgl;
        logic rdOut;
        logic rdOe;
    } tcrm_link_s;

    typedef struct packed {
        logic tglSync1;
        logic tglSync2;
        logic tglSeen;
        logic [7:0] txPower;
        logic [7:0] priSens;
        logic [7:0] altSens;
        logic [7:0] actSens;
        logic altSel;
    } tcrm_core_s;
endpackage

/* verif/tcrm_ctl_model.sv */
// Purpose: Controller model that masters the serial control link.
// Assumes: Clock stays low between frames, write line idles low, read line has a pull-up.
// Notes: A stall argument halts the clock mid-frame to exercise the static slave logic.
`timescale 1ns/1ps
`default_nettype none
module tcrm_ctl_model (
    output logic sclk, // Serial clock
    output logic swdat, // Write data
    input wire logic srdatOut, // Device read bit
    input wire logic srdatOe, // Device drive enable
    output logic drove // Device drove during the last frame
);
    wire line = srdatOe ? srdatOut : 1'b1; // Pull-up once released
    initial
    begin
        sclk = 1'b0;
        swdat = 1'b0;
        drove = 1'b0;
    end
    // One 32 ns period; data changes only while the clock is low
    task automatic tick(input logic b, output logic s);
        swdat = b;
        #12 s = line;
        sclk = 1'b1;
        #1 drove = drove | srdatOe;
        #15 sclk = 1'b0;
        #4;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] e, input logic [7:0] d,
                         input int nb, input int stall, output logic [7:0] q);
        logic [23:0] bits;
        logic s;
        bits = {cmd, e, d};
        drove = 1'b0;
        q = 8'h00;
        tick(1'b1, s);
        for (int i = 1; i <= 8 + 8 * nb; i++)
        begin
            if (i == stall)
                #2000;
            tick(bits[24 - i], s);
            q = {q[6:0], s};
        end
        // Idle low, and let time pass so a following start bit is a separate change
        swdat = 1'b0;
        #4;
    endtask
endmodule
`default_nettype wire

/* verif/tcrm_transceiver_regs_tb.sv */
// Purpose: Self-checking bench for the transceiver register bank.
// Assumes: Link clock of 32 ns from the controller model, core clock of 4 ns.
// Notes: Partly reserved capability inputs are all ones, so reserved bits must mask out.
`timescale 1ns/1ps
`default_nettype none
module tcrm_transceiver_regs_tb;
    import tcrm_pkg::*;
    localparam logic [2:0] ADDR = 3'h2;
    localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value
    localparam logic [5:0] PART = 6'h2D; // Arbitrary value
    logic core_clk = 1'b0;
    logic rstn = 1'b1;
    wire sclk, swdat, srdatOut, srdatOe, drove;
    logic [7:0] txP, pri, alt, act, q;
    logic altSel;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] rsv [4] = '{8'h0F, 8'hEF, 8'hF0, 8'hFF};
    logic [7:0] xe [15] = '{MAKER, {2'h0, PART}, 8'hFF, 8'hFF, {1'b0, STAB_50MS, 1'b0, RECOV_10MS},
        {1'b0, SPEED_1M, 1'b0, FLAGS_12}, 8'h0E, 8'h01, MODES_SEC_VALID, SUBC_BB_VALID,
        SUBC_30_VALID, 8'h00, 8'h00, SUBC_52_VALID, SUBC_HI_VALID};
    always #2 core_clk = ~core_clk;
    tcrm_transceiver_regs #(.DEV_ADDR(ADDR), .MAKER_ID(MAKER), .PART_TYPE(PART),
        .RECOV_CODE(RECOV_10MS), .STAB_CODE(STAB_50MS), .FLAGS_CODE(FLAGS_12),
        .SPEED_CODE(SPEED_1M), .MODES_SEC(8'hFF),
        .SUBC_BB(8'hFF), .SUBC_30(8'hFF), .SUBC_52(8'hFF),
        .SUBC_HI(8'hFF)) tcrm_transceiver_regs_i (.core_clk(core_clk), .rstn(rstn),
        .sclk(sclk), .swdat(swdat), .srdatOut(srdatOut), .srdatOe(srdatOe),
        .txPowerLevel(txP), .priSensitivity(pri), .altSensitivity(alt),
        .activeSensitivity(act), .altSensSelected(altSel));
    tcrm_ctl_model tcrm_ctl_model_i (.sclk(sclk), .swdat(swdat), .srdatOut(srdatOut),
        .srdatOe(srdatOe), .drove(drove));
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Core copies settle on the third core clock edge after the link write
    task automatic outs(input logic [7:0] p, input logic [7:0] s1, input logic [7:0] s2,
                        input logic [7:0] s3, input logic s);
        repeat (8) @(posedge core_clk);
        chk("outputs", {p, s1, s2, s3, 7'h0, s}, {txP, pri, alt, act, 7'h0, altSel});
    endtask
    task automatic acc(input logic [2:0] a, input logic [3:0] ix, input logic [7:0] ei,
                       input logic [7:0] d, input logic w, input int st);
        if (ix == IDX_ESCAPE)
            tcrm_ctl_model_i.frame({a, ix, w}, ei, d, 2, st, q);
        else
            tcrm_ctl_model_i.frame({a, ix, w}, d, 8'h00, 1, st, q);
    endtask
    task automatic results();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        // A real falling edge, so both domains see the asynchronous reset
        #1 rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (3) tcrm_ctl_model_i.tick(1'b0, q[0]);
        outs(8'hFF, 8'h7F, 8'h7F, 8'h7F, 1'b0);
        for (int i = 0; i < 15; i++)
        begin
            acc(ADDR, IDX_ESCAPE, 8'(i), 8'h00, 1'b0, 0);
            chk("ext data", xe[i], q);
            chk("ext drive", i != 2 && i != 3, drove);
        end
        foreach (rsv[k])
        begin
            acc(ADDR, IDX_ESCAPE, rsv[k], 8'h00, 1'b0, 0);
            chk("rsv drive", 1'b0, drove);
        end
        acc(ADDR, IDX_TX_POWER, 8'h00, 8'h00, DIR_WRITE, 0);
        outs(8'h00, 8'h7F, 8'h7F, 8'h7F, 1'b0);
        acc(ADDR, IDX_ALT_SENS, 8'h00, 8'h34, DIR_WRITE, 12);
        outs(8'h00, 8'h7F, 8'h34, 8'h34, 1'b1);
        acc(ADDR, IDX_PRI_SENS, 8'h00, 8'h12, DIR_WRITE, 0);
        outs(8'h00, 8'h12, 8'h34, 8'h12, 1'b0);
        acc(ADDR, IDX_PRI_SENS, 8'h00, 8'h00, 1'b0, 0);
        chk("main read", 8'h12, q);
        for (int i = 5; i < 12; i++)
        begin
            acc(ADDR, 4'(i), 8'h00, 8'hFF, DIR_WRITE, 0);
            acc(ADDR, 4'(i), 8'h00, 8'h00, 1'b0, 0);
            chk("main rsv drive", 1'b0, drove);
        end
        acc(ADDR, IDX_ESCAPE, EXT_FEATURES, 8'h00, DIR_WRITE, 0);
        acc(ADDR + 3'h1, IDX_TX_POWER, 8'h00, 8'hFF, DIR_WRITE, 0);
        acc(ADDR_BCAST, IDX_TX_POWER, 8'h00, 8'h00, 1'b0, 0);
        chk("bcast drive", 1'b0, drove);
        outs(8'h00, 8'h12, 8'h34, 8'h12, 1'b0);
        acc(ADDR, IDX_ALT_SENS, 8'h00, 8'hFF, DIR_WRITE, 0);
        tcrm_ctl_model_i.frame({ADDR, IDX_AGC, DIR_WRITE}, 8'h00, 8'h00, 0, 0, q);
        outs(8'h00, 8'h12, 8'hFF, 8'h12, 1'b0);
        acc(ADDR_BCAST, IDX_TX_POWER, 8'h00, 8'hC0, DIR_WRITE, 0);
        outs(8'hC0, 8'h12, 8'hFF, 8'h12, 1'b0);
        tcrm_ctl_model_i.frame({ADDR, IDX_RESET, DIR_WRITE}, 8'h00, 8'h00, 0, 0, q);
        outs(8'hFF, 8'h7F, 8'h7F, 8'h7F, 1'b0);
        results();
    end
    initial
    begin
        #200000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
